// File: core/imu_fifo_frame_content_config.v
// queue frame content configuration: registers, frame builder, tagging and readout
`timescale 1ns/1ps
`include "imu_fifo_cfg_regs.vh"
module imu_fifo_frame_content_config #(
    parameter DW    = 48,
    parameter TW    = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire            i_clk,
    input  wire            i_reset_n,
    input  wire            i_ce,
    input  wire [7:0]      i_reg_addr,
    input  wire [7:0]      i_reg_wdata,
    input  wire            i_reg_wr,
    input  wire            i_reg_rd,
    output reg  [7:0]      o_reg_rdata,
    output reg             o_reg_rvalid,
    input  wire            i_int_line_one,
    input  wire            i_int_line_two,
    input  wire            i_acc_sat,
    input  wire            i_gyr_sat,
    input  wire            i_acc_valid,
    input  wire [DW-1:0]   i_acc_data,
    input  wire            i_gyr_valid,
    input  wire [DW-1:0]   i_gyr_data,
    input  wire            i_aux_valid,
    input  wire [DW-1:0]   i_aux_data,
    input  wire [TW-1:0]   i_sensor_time,
    output reg             o_frame_valid,
    output reg  [DW+4:0]   o_frame_data,
    input  wire            i_frame_ready
);
    localparam FW = DW + 5;
    localparam [7:0] RST_CFG0 = `RST_FULLNESS_TIME; // reset image of the first register
    localparam [7:0] RST_CFG1 = `RST_SOURCE_TAG;    // reset image of the second register

    // configuration registers
    reg        halt_on_full_q;
    reg        time_append_q;
    reg [1:0]  tag_source_line_one_select;
    reg [1:0]  tag_source_line_two_select;
    reg        header_store_q;
    reg        aux_store_q;
    reg        acc_store_q;
    reg        gyr_store_q;

    // pin synchronisers and edge memory
    reg        line_one_meta_q;
    reg        line_one_sync_q;
    reg        line_one_prev_q;
    reg        line_two_meta_q;
    reg        line_two_sync_q;
    reg        line_two_prev_q;
    reg        edge_one_q;
    reg        edge_two_q;

    // pending samples waiting for the queue
    reg          acc_pend_q;
    reg          gyr_pend_q;
    reg          aux_pend_q;
    reg [DW-1:0] acc_hold_q;
    reg [DW-1:0] gyr_hold_q;
    reg [DW-1:0] aux_hold_q;

    // readout side
    reg          time_owed_q;

    wire          q_in_ready;
    wire          q_out_valid;
    wire [FW-1:0] q_out_data;
    reg  [FW-1:0] push_word;
    reg  [1:0]    push_kind;
    reg  [DW-1:0] push_payload;
    reg           tag_one;
    reg           tag_two;

    wire push_valid = acc_pend_q || gyr_pend_q || aux_pend_q;
    wire push_fire  = push_valid && q_in_ready;
    wire out_free   = !o_frame_valid || i_frame_ready;
    wire q_pop      = out_free && q_out_valid;
    wire time_load  = out_free && !q_out_valid && time_owed_q && time_append_q;

    // register writes
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            halt_on_full_q             <= RST_CFG0[`BIT_HALT_ON_FULL];
            time_append_q              <= RST_CFG0[`BIT_TIME_APPEND];
            tag_source_line_one_select <= RST_CFG1[`MSB_TAG_LINE_ONE:`LSB_TAG_LINE_ONE];
            tag_source_line_two_select <= RST_CFG1[`MSB_TAG_LINE_TWO:`LSB_TAG_LINE_TWO];
            header_store_q             <= RST_CFG1[`BIT_HEADER_STORE];
            aux_store_q                <= RST_CFG1[`BIT_AUX_STORE];
            acc_store_q                <= RST_CFG1[`BIT_ACC_STORE];
            gyr_store_q                <= RST_CFG1[`BIT_GYR_STORE];
        end
        else if (i_ce && i_reg_wr)
        begin
            if (i_reg_addr == `OFS_FULLNESS_TIME)
            begin
                halt_on_full_q <= i_reg_wdata[`BIT_HALT_ON_FULL];
                time_append_q  <= i_reg_wdata[`BIT_TIME_APPEND];
            end
            if (i_reg_addr == `OFS_SOURCE_TAG)
            begin
                tag_source_line_one_select <= i_reg_wdata[`MSB_TAG_LINE_ONE:`LSB_TAG_LINE_ONE];
                tag_source_line_two_select <= i_reg_wdata[`MSB_TAG_LINE_TWO:`LSB_TAG_LINE_TWO];
                header_store_q <= i_reg_wdata[`BIT_HEADER_STORE];
                aux_store_q    <= i_reg_wdata[`BIT_AUX_STORE];
                acc_store_q    <= i_reg_wdata[`BIT_ACC_STORE];
                gyr_store_q    <= i_reg_wdata[`BIT_GYR_STORE];
            end
        end
    end

    // register reads, one cycle after the strobe; reserved bits read zero
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end
        else if (i_ce)
        begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    `OFS_FULLNESS_TIME: o_reg_rdata <= {6'h00, time_append_q, halt_on_full_q};
                    `OFS_SOURCE_TAG:    o_reg_rdata <= {gyr_store_q, acc_store_q, aux_store_q,
                                                        header_store_q,
                                                        tag_source_line_two_select,
                                                        tag_source_line_one_select};
                    default:            o_reg_rdata <= `RD_UNMAPPED;
                endcase
            end
        end
    end

    // interrupt lines come from pins: two flops, then a third for edge detection
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            line_one_meta_q <= 1'b0;
            line_one_sync_q <= 1'b0;
            line_one_prev_q <= 1'b0;
            line_two_meta_q <= 1'b0;
            line_two_sync_q <= 1'b0;
            line_two_prev_q <= 1'b0;
        end
        else if (i_ce)
        begin
            line_one_meta_q <= i_int_line_one;
            line_one_sync_q <= line_one_meta_q;
            line_one_prev_q <= line_one_sync_q;
            line_two_meta_q <= i_int_line_two;
            line_two_sync_q <= line_two_meta_q;
            line_two_prev_q <= line_two_sync_q;
        end
    end

    // sticky rising-edge memory, cleared by the frame that carries it; a new edge wins
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            edge_one_q <= 1'b0;
            edge_two_q <= 1'b0;
        end
        else if (i_ce)
        begin
            if (line_one_sync_q && !line_one_prev_q)
                edge_one_q <= 1'b1;
            else if (push_fire)
                edge_one_q <= 1'b0;
            if (line_two_sync_q && !line_two_prev_q)
                edge_two_q <= 1'b1;
            else if (push_fire)
                edge_two_q <= 1'b0;
        end
    end

    // tag bit chosen by each selector
    always @*
    begin
        case (tag_source_line_one_select)
            `TAG_SEL_EDGE:    tag_one = edge_one_q;
            `TAG_SEL_LEVEL:   tag_one = line_one_sync_q;
            `TAG_SEL_ACC_SAT: tag_one = i_acc_sat;
            `TAG_SEL_GYR_SAT: tag_one = i_gyr_sat;
            default:          tag_one = 1'b0;
        endcase
        case (tag_source_line_two_select)
            `TAG_SEL_EDGE:    tag_two = edge_two_q;
            `TAG_SEL_LEVEL:   tag_two = line_two_sync_q;
            `TAG_SEL_ACC_SAT: tag_two = i_acc_sat;
            `TAG_SEL_GYR_SAT: tag_two = i_gyr_sat;
            default:          tag_two = 1'b0;
        endcase
    end

    // sample capture; a sample is only taken for an enabled source
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            acc_pend_q <= 1'b0;
            gyr_pend_q <= 1'b0;
            aux_pend_q <= 1'b0;
            acc_hold_q <= {DW{1'b0}};
            gyr_hold_q <= {DW{1'b0}};
            aux_hold_q <= {DW{1'b0}};
        end
        else if (i_ce)
        begin
            if (i_aux_valid && aux_store_q)
            begin
                aux_pend_q <= 1'b1;
                aux_hold_q <= i_aux_data;
            end
            else if (!aux_store_q || (push_fire && push_kind == `KIND_AUX))
                aux_pend_q <= 1'b0;
            if (i_gyr_valid && gyr_store_q)
            begin
                gyr_pend_q <= 1'b1;
                gyr_hold_q <= i_gyr_data;
            end
            else if (!gyr_store_q || (push_fire && push_kind == `KIND_GYR))
                gyr_pend_q <= 1'b0;
            if (i_acc_valid && acc_store_q)
            begin
                acc_pend_q <= 1'b1;
                acc_hold_q <= i_acc_data;
            end
            else if (!acc_store_q || (push_fire && push_kind == `KIND_ACC))
                acc_pend_q <= 1'b0;
        end
    end

    // frame assembly: gyroscope, then accelerometer, then auxiliary
    always @*
    begin
        push_kind    = `KIND_AUX;
        push_payload = aux_hold_q;
        if (gyr_pend_q)
        begin
            push_kind    = `KIND_GYR;
            push_payload = gyr_hold_q;
        end
        else if (acc_pend_q)
        begin
            push_kind    = `KIND_ACC;
            push_payload = acc_hold_q;
        end
        if (header_store_q)
            push_word = {1'b1, push_kind, tag_two, tag_one, push_payload};
        else
            push_word = {5'h00, push_payload};
    end

    // queue: a full queue stalls the writer when halting, else drops the oldest
    frame_queue #(
        .WIDTH (FW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_queue (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_ce        (i_ce),
        .i_in_valid  (push_valid),
        .o_in_ready  (q_in_ready),
        .i_in_data   (push_word),
        .i_overwrite (!halt_on_full_q),
        .o_out_valid (q_out_valid),
        .i_out_ready (q_pop),
        .o_out_data  (q_out_data),
        .o_count     ()
    );

    // readout stage; a time frame follows the last data frame when enabled
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_frame_valid <= 1'b0;
            o_frame_data  <= {FW{1'b0}};
            time_owed_q   <= 1'b0;
        end
        else if (i_ce)
        begin
            if (q_pop)
            begin
                o_frame_valid <= 1'b1;
                o_frame_data  <= q_out_data;
                time_owed_q   <= 1'b1;
            end
            else if (time_load)
            begin
                o_frame_valid <= 1'b1;
                o_frame_data  <= {1'b1, `KIND_TIME, 2'h0,
                                  {(DW-TW){1'b0}}, i_sensor_time};
                time_owed_q   <= 1'b0;
            end
            else
            begin
                if (out_free)
                    o_frame_valid <= 1'b0;
                if (!time_append_q)
                    time_owed_q <= 1'b0;
            end
        end
    end
endmodule // imu_fifo_frame_content_config

// File: core/imu_fifo_cfg_regs.vh
// register offsets, field positions, reset values and frame codes for the queue config block
`ifndef IMU_FIFO_CFG_REGS_VH
`define IMU_FIFO_CFG_REGS_VH

// register offsets on the serial register port
`define OFS_FULLNESS_TIME    8'h48
`define OFS_SOURCE_TAG       8'h49

// reset values
`define RST_FULLNESS_TIME    8'h02
`define RST_SOURCE_TAG       8'h10

// fields of queue_fullness_time_config
`define BIT_HALT_ON_FULL     0
`define BIT_TIME_APPEND      1

// fields of queue_source_tag_config
`define LSB_TAG_LINE_ONE     0
`define MSB_TAG_LINE_ONE     1
`define LSB_TAG_LINE_TWO     2
`define MSB_TAG_LINE_TWO     3
`define BIT_HEADER_STORE     4
`define BIT_AUX_STORE        5
`define BIT_ACC_STORE        6
`define BIT_GYR_STORE        7

// tag source selector codes
`define TAG_SEL_EDGE         2'h0
`define TAG_SEL_LEVEL        2'h1
`define TAG_SEL_ACC_SAT      2'h2
`define TAG_SEL_GYR_SAT      2'h3

// frame kind codes carried in the header field
`define KIND_ACC             2'h0
`define KIND_GYR             2'h1
`define KIND_AUX             2'h2
`define KIND_TIME            2'h3

// register read value for unmapped offsets
`define RD_UNMAPPED          8'h00

`endif

// File: core/frame_queue.v
// frame queue with valid/ready on both sides and optional drop-oldest on full
`timescale 1ns/1ps
module frame_queue #(
    parameter WIDTH = 53,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_clk,
    input  wire             i_reset_n,
    input  wire             i_ce,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    input  wire             i_overwrite,
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data,
    output wire [AW:0]      o_count
);
    localparam [AW:0] DEPTH_C = DEPTH;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;

    wire full  = (cnt_q == DEPTH_C);
    wire empty = (cnt_q == {(AW+1){1'b0}});
    wire pop   = i_out_ready && !empty;
    wire push  = i_in_valid && (!full || pop || i_overwrite);
    wire evict = push && full && !pop; // oldest word gives way to the new one

    assign o_in_ready  = !full || pop || i_overwrite;
    assign o_out_valid = !empty;
    assign o_out_data  = mem[rd_q];
    assign o_count     = cnt_q;

    // storage array, no reset needed
    always @(posedge i_clk)
    begin
        if (i_ce && push)
            mem[wr_q] <= i_in_data;
    end

    // pointers and fill count
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else if (i_ce)
        begin
            if (push)
                wr_q <= (wr_q == DEPTH_C[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            if (pop || evict)
                rd_q <= (rd_q == DEPTH_C[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            if (push && !pop && !evict)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // frame_queue

// File: sim/imu_cfg_checker_assertions.sv
// port checker for the queue frame content configuration block
`timescale 1ns/1ps
module imu_cfg_checker #(
    parameter DW = 48,
    parameter TW = 24
) (
    input wire          i_clk,
    input wire          i_reset_n,
    input wire          i_ce,
    input wire [7:0]    i_reg_addr,
    input wire [7:0]    i_reg_wdata,
    input wire          i_reg_wr,
    input wire          i_reg_rd,
    input wire [7:0]    o_reg_rdata,
    input wire          o_reg_rvalid,
    input wire          o_frame_valid,
    input wire [DW+4:0] o_frame_data,
    input wire          i_frame_ready
);
    reg  [1:0] cfg0_q;
    reg  [7:0] cfg1_q;
    wire       rd   = i_ce & i_reg_rd;
    wire       map  = (i_reg_addr == 8'h48) || (i_reg_addr == 8'h49);
    wire [1:0] kind = o_frame_data[DW+3:DW+2];
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // shadow of the written settings
    always @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cfg0_q <= 2'h2;
            cfg1_q <= 8'h10;
        end
        else if (i_ce && i_reg_wr && i_reg_addr == 8'h48)
            cfg0_q <= i_reg_wdata[1:0];
        else if (i_ce && i_reg_wr && i_reg_addr == 8'h49)
            cfg1_q <= i_reg_wdata;
    end
    chk_rvalid_pulse: assert property (i_ce |=> o_reg_rvalid == $past(i_reg_rd))
        else $error("read answer strobe wrong");
    chk_cfg0_read: assert property (rd && i_reg_addr == 8'h48 |=>
        o_reg_rdata == {6'h0, $past(cfg0_q)}) else $error("first setting read wrong");
    chk_cfg1_read: assert property (rd && i_reg_addr == 8'h49 |=>
        o_reg_rdata == $past(cfg1_q)) else $error("second setting read wrong");
    chk_unmapped_zero: assert property (rd && !map |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    chk_frame_hold: assert property (o_frame_valid && !(i_ce && i_frame_ready) |=>
        o_frame_valid && $stable(o_frame_data)) else $error("frame dropped while stalled");
    chk_ce_freeze: assert property (!i_ce |=> $stable(o_frame_valid) && $stable(o_reg_rvalid))
        else $error("state moved with enable low");
    chk_source_enabled: assert property (
        o_frame_valid && o_frame_data[DW+4] && kind != 2'h3 |->
        (kind == 2'h0 ? cfg1_q[6] : kind == 2'h1 ? cfg1_q[7] : cfg1_q[5]))
        else $error("frame of disabled source");
    chk_headerless_zero: assert property (o_frame_valid && !cfg1_q[4] |->
        o_frame_data[DW+4:DW] == 5'h0) else $error("header bits in headerless frame");
    chk_time_frame: assert property (o_frame_valid && o_frame_data[DW+4:DW+2] == 3'h7 |->
        cfg0_q[1] && o_frame_data[DW+1:TW] == 0) else $error("time frame wrong");
    cover property (rd && i_reg_addr == 8'h49);
    cover property (o_frame_valid && i_frame_ready && kind == 2'h3);
    cover property (o_frame_valid && !i_frame_ready ##1 o_frame_valid && i_frame_ready);
endmodule // imu_cfg_checker

bind imu_fifo_frame_content_config imu_cfg_checker #(.DW(DW), .TW(TW)) u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_frame_valid(o_frame_valid),
    .o_frame_data(o_frame_data), .i_frame_ready(i_frame_ready));

// File: sim/frame_sink.sv
// readout partner that accepts frames with random or forced stalls
`timescale 1ns/1ps
module frame_sink (
    input  wire i_clk,
    input  wire i_hold,
    input  wire i_rnd,
    output reg  o_ready
);
    reg want_q = 1'b0;
    initial o_ready = 1'b0;
    // hold and random draw sampled on the rising edge, away from where the bench moves hold
    always @(posedge i_clk)
        want_q <= !i_hold && i_rnd;
    // ready shown off the sampling edge of the design
    always @(negedge i_clk)
        o_ready <= want_q;
endmodule // frame_sink

// File: sim/imu_fifo_frame_content_config_tb_top.sv
// self-checking bench for the queue frame content configuration block
`timescale 1ns/1ps
`include "imu_fifo_cfg_regs.vh"
module imu_fifo_frame_content_config_tb_top;
    localparam DW = 48;
    reg           i_clk, i_reset_n, i_ce, i_reg_wr, i_reg_rd, hold, rnd, stage, lat, halt, tm;
    reg  [7:0]    i_reg_addr, i_reg_wdata, cfg1;
    reg           i_int_line_one, i_int_line_two, i_acc_sat, i_gyr_sat, sk1, sk2;
    reg           i_acc_valid, i_gyr_valid, i_aux_valid;
    reg  [DW-1:0] i_acc_data, i_gyr_data, i_aux_data;
    reg  [23:0]   i_sensor_time;
    reg  [31:0]   lfsr_q, rt;
    wire [7:0]    o_reg_rdata;
    wire          o_reg_rvalid, o_frame_valid, i_frame_ready;
    wire [DW+4:0] o_frame_data;
    reg  [DW+4:0] exp_q[$], mq[$], lat_f;
    integer       n_fail, checked, i, k, m;
    function [31:0] nxt(input [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function tagv(input [1:0] s, input ln, input sk);
        tagv = (s == 2'h0) ? sk : (s == 2'h1) ? ln : (s == 2'h2) ? i_acc_sat : i_gyr_sat;
    endfunction
    imu_fifo_frame_content_config uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_int_line_one(i_int_line_one), .i_int_line_two(i_int_line_two),
        .i_acc_sat(i_acc_sat), .i_gyr_sat(i_gyr_sat), .i_acc_valid(i_acc_valid),
        .i_acc_data(i_acc_data), .i_gyr_valid(i_gyr_valid), .i_gyr_data(i_gyr_data),
        .i_aux_valid(i_aux_valid), .i_aux_data(i_aux_data), .i_sensor_time(i_sensor_time),
        .o_frame_valid(o_frame_valid), .o_frame_data(o_frame_data),
        .i_frame_ready(i_frame_ready));
    frame_sink u_sink (.i_clk(i_clk), .i_hold(hold), .i_rnd(rnd), .o_ready(i_frame_ready));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // random ready pattern for the sink
    always @(posedge i_clk)
    begin
        rt = nxt(rt);
        rnd <= rt[0] | rt[1];
    end
    // every accepted frame is compared with the model
    always @(posedge i_clk)
        if (i_reset_n && i_ce && o_frame_valid && i_frame_ready)
            cmp_frame(o_frame_data);
    task conclude;
        begin
            if (n_fail == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task cmp_frame(input [DW+4:0] got);
        begin
            checked = checked + 1;
            if (exp_q.size() == 0)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] frame expected none got %h", got);
            end
            else if (exp_q[0] !== got)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] frame expected %h got %h", exp_q[0], got);
            end
            if (exp_q.size() > 0)
                exp_q.pop_front();
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            i_reg_addr = a;
            i_reg_wdata = d;
            i_reg_wr = 1'b1;
            @(negedge i_clk) i_reg_wr = 1'b0;
            @(negedge i_clk); // let an edge pass before the next strobe
        end
    endtask
    task rd_chk(input [7:0] a, input [7:0] e);
        begin
            i_reg_addr = a;
            i_reg_rd = 1'b1;
            @(negedge i_clk) i_reg_rd = 1'b0;
            checked = checked + 1;
            if (o_reg_rvalid !== 1'b1 || o_reg_rdata !== e)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] reg %h expected %h got %h", a, e, o_reg_rdata);
            end
            @(negedge i_clk); // let an edge pass before the next strobe
        end
    endtask
    task push_model(input [DW+4:0] f);
        begin
            if (!hold)
                exp_q.push_back(f);
            else if (!stage)
            begin
                stage = 1'b1;
                exp_q.push_back(f);
            end
            else if (mq.size() < 8)
                mq.push_back(f);
            else if (halt)
            begin
                lat = 1'b1;
                lat_f = f;
            end
            else
            begin
                mq.pop_front();
                mq.push_back(f);
            end
        end
    endtask
    // one sample per source in sm, queued in order gyroscope, accelerometer, auxiliary
    task send(input [2:0] sm);
        reg [1:0]    kd;
        reg [DW-1:0] dv;
        integer      j;
        begin
            lfsr_q = nxt(lfsr_q);
            i_acc_data = {lfsr_q[15:0], nxt(lfsr_q)};
            i_gyr_data = {lfsr_q, lfsr_q[31:16]};
            i_aux_data = {nxt(lfsr_q), lfsr_q[23:8]};
            {i_aux_valid, i_gyr_valid, i_acc_valid} = sm;
            for (j = 0; j < 3; j = j + 1)
            begin
                kd = (j == 0) ? 2'h1 : (j == 1) ? 2'h0 : 2'h2;
                dv = (j == 0) ? i_gyr_data : (j == 1) ? i_acc_data : i_aux_data;
                if (sm[kd] && cfg1[7 - j])
                begin
                    push_model(cfg1[4] ? {1'b1, kd, tagv(cfg1[3:2], i_int_line_two, sk2),
                        tagv(cfg1[1:0], i_int_line_one, sk1), dv} : {5'h0, dv});
                    sk1 = 1'b0;
                    sk2 = 1'b0;
                end
            end
            if (tm)
                exp_q.push_back({5'h1C, 24'h0, i_sensor_time});
            @(negedge i_clk);
            {i_aux_valid, i_gyr_valid, i_acc_valid} = 3'h0;
            repeat (4) @(negedge i_clk);
        end
    endtask
    task drain;
        integer t;
        begin
            t = 0;
            while ((exp_q.size() != 0 || o_frame_valid !== 1'b0) && t < 300)
            begin
                @(negedge i_clk);
                t = t + 1;
            end
            if (exp_q.size() != 0 || o_frame_valid !== 1'b0)
            begin
                n_fail = n_fail + 1;
                $display("[FAIL] drain expected empty got %0d", exp_q.size());
                conclude;
            end
        end
    endtask
    // main sequence
    initial
    begin
        {i_reset_n, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, hold, rnd, tm} = 0;
        {i_int_line_one, i_int_line_two, i_acc_sat, i_gyr_sat, sk1, sk2} = 0;
        {i_acc_valid, i_gyr_valid, i_aux_valid, i_acc_data, i_gyr_data, i_aux_data} = 0;
        i_sensor_time = 24'h0;
        i_ce = 1'b1;
        lfsr_q = 32'h996755A8;
        rt = 32'h996755A8;
        n_fail = 0;
        checked = 0;
        repeat (20) @(negedge i_clk);
        i_reset_n = 1'b1;
        rd_chk(`OFS_FULLNESS_TIME, `RST_FULLNESS_TIME);
        rd_chk(`OFS_SOURCE_TAG, `RST_SOURCE_TAG);
        wr(8'h4A, 8'hFF);
        rd_chk(8'h4A, `RD_UNMAPPED);
        wr(`OFS_FULLNESS_TIME, 8'hFC);
        rd_chk(`OFS_FULLNESS_TIME, 8'h00);
        // all source masks and selector codes, random lines and saturation
        for (m = 0; m < 16; m = m + 1)
        begin
            lfsr_q = nxt(lfsr_q);
            sk1 = sk1 | (lfsr_q[0] & ~i_int_line_one);
            sk2 = sk2 | (lfsr_q[1] & ~i_int_line_two);
            {i_gyr_sat, i_acc_sat, i_int_line_two, i_int_line_one} = lfsr_q[3:0];
            cfg1 = {m[2:0], 1'b1, m[1:0], m[3:2]};
            wr(`OFS_SOURCE_TAG, cfg1);
            rd_chk(`OFS_SOURCE_TAG, cfg1);
            send(3'h7);
            drain;
        end
        // headerless storage, both sensors sampled together at one rate
        cfg1 = 8'hC0;
        wr(`OFS_SOURCE_TAG, cfg1);
        send(3'h7);
        drain;
        // time frame after the last data frame
        cfg1 = 8'h50;
        wr(`OFS_SOURCE_TAG, cfg1);
        wr(`OFS_FULLNESS_TIME, 8'h02);
        tm = 1'b1;
        i_sensor_time = lfsr_q[23:0];
        send(3'h1);
        drain;
        tm = 1'b0;
        // overflow with the reader stalled, wrap then halt
        for (k = 0; k < 2; k = k + 1)
        begin
            halt = k;
            wr(`OFS_FULLNESS_TIME, {7'h0, halt});
            {hold, stage, lat} = 3'h4;
            repeat (3) @(negedge i_clk);
            for (i = 0; i < 12; i = i + 1)
                send(3'h1);
            i_ce = 1'b0;
            repeat (3) @(negedge i_clk);
            i_ce = 1'b1;
            while (mq.size() > 0)
                exp_q.push_back(mq.pop_front());
            if (lat)
                exp_q.push_back(lat_f);
            hold = 1'b0;
            drain;
        end
        conclude;
    end
endmodule // imu_fifo_frame_content_config_tb_top
